// ==== sram_host_defines.svh ====
/*
  timing constants for the host controller of the async byte-lane memory.
  assumes the controller clock runs at 25 MHz (40 ns period).
*/
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH

// clock period in picoseconds
`define CLK_PERIOD_PS 40000
// supply settle wait before first access, in nanoseconds
`define SUPPLY_SETTLE_TIME_NS 100000
// least time, rounded up to whole cycles
`define SUPPLY_SETTLE_CYC ((`SUPPLY_SETTLE_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// memory output turn-off after store strobe falls, picoseconds
`define STORE_TURNOFF_DELAY_PS 5000
// write data lead before write end, picoseconds
`define DATA_LEAD_TIME_PS 5000
// least store strobe width, rounded up, at least one cycle
`define STORE_LOW_CYC ((`STORE_TURNOFF_DELAY_PS + `DATA_LEAD_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// read access time (address and select to data), picoseconds
`define READ_ACCESS_PS 10000
`define READ_WAIT_CYC ((`READ_ACCESS_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// bus release time after read (output drive off to high-z), picoseconds
`define RELEASE_PS 6000
`define RELEASE_CYC ((`RELEASE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== sram_host_pkg.sv ====
/*
  types shared by the host controller files.
  assumes sram_host_defines.svh supplies the numeric constants.
*/
package sram_host_pkg;

  // controller sequencer states
  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_READ,
    ST_READ_DONE,
    ST_TURN,
    ST_WRITE,
    ST_WRITE_END
  } host_state_t;

endpackage

// ==== sram_host_timer.sv ====
/*
  down counter used to time the memory's pin phases.
  assumes one clock; load takes priority over counting.
*/
module sram_host_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);

  initial begin
    if (WIDTH < 2) begin
      $error("timer width too small");
    end
  end

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  wire logic count_zero = (count_ff == '0);

  // reload or count toward zero
  assign nxt_count = load ? load_val :
                     (count_zero ? count_ff : count_ff - WIDTH'(1));
  assign done = count_zero & ~load;

  ////////////////////////////////////////////////////////////////////////
  // count register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule

// ==== sram_host_ctrl.sv ====
/*
  host controller for an asynchronous 16-bit memory with byte lanes.
  turns single read/write requests into pin sequences on the chip select,
  output drive, store strobe, byte selects, address and data pins.
  assumes REF_CLK at 25 MHz, SYS_RST asserted while the supply settles.
*/
// Overview of operation
// R1 - memory drives lanes whose select is low
// R2 - memory stores selected lanes during write
// R3 - memory high-z when deselected or disabled
// R4 - write starts when all controls low
// R5 - write ends on first rising control
// R6 - store strobe high throughout every read
// R7 - no write data until memory outputs off
// R8 - strobe low for turnoff plus data lead
// R9 - address valid by chip select fall
// R10 - wait supply settle time before access
// R11 - memory releases faster than it drives
// R12 - memory corrects single-bit errors on read
// R13 - memory never writes corrected word back
// R14 - release read drivers before host drives
`include "sram_host_defines.svh"
module sram_host_ctrl #(
  parameter int ADDR_W = 19,
  parameter int SETTLE_CYC = `SUPPLY_SETTLE_CYC
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [1:0] REQ_LANES,
  input wire logic [15:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [15:0] RSP_RDATA,
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic CHIP_SEL_N,
  output logic OUT_DRIVE_N,
  output logic STORE_N,
  output logic LOW_BYTE_SEL_N,
  output logic HIGH_BYTE_SEL_N,
  input wire logic [15:0] DQ_IN,
  output logic [15:0] DQ_OUT,
  output logic DQ_OE
);

  localparam int TW = 23;
  localparam logic [TW-1:0] SETTLE_LD = TW'(SETTLE_CYC - 1);
  localparam logic [TW-1:0] STORE_LD = TW'(`STORE_LOW_CYC);
  // read hold covers the access plus the two data synchroniser stages
  localparam logic [TW-1:0] READ_LD = TW'(`READ_WAIT_CYC + 2);
  localparam logic [TW-1:0] RELEASE_LD = TW'(`RELEASE_CYC);

  initial begin
    if (ADDR_W < 1 || ADDR_W > 32) begin
      $error("address width out of range");
    end
    if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << TW)) begin
      $error("settle count does not fit the timer");
    end
  end

  sram_host_pkg::host_state_t state_ff;
  sram_host_pkg::host_state_t nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic [1:0] lanes_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic rsp_ff;
  logic cs_n_ff;
  logic oe_n_ff;
  logic we_n_ff;
  logic dq_oe_ff;
  logic [15:0] dq_s1_ff;
  logic [15:0] dq_s2_ff;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;
  logic kick_ff;

  ////////////////////////////////////////////////////////////////////////
  // phase timer
  sram_host_timer #(.WIDTH(TW)) u_timer (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // decode of sequencer conditions
  wire logic in_idle = (state_ff == sram_host_pkg::ST_IDLE);
  wire logic lanes_ok = |REQ_LANES;
  // requests with no lane are never taken, so nothing is latched for them
  wire logic take_req = in_idle & REQ_VALID & lanes_ok;

  // next state and timer loads
  always_comb begin
    nxt_state = state_ff;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_ff)
      sram_host_pkg::ST_POWERUP: begin
        if (kick_ff) begin
          // first cycle out of reset starts the settle count
          tmr_load = 1'b1;
          tmr_val = SETTLE_LD; // R10
        end else if (tmr_done) begin
          nxt_state = sram_host_pkg::ST_IDLE; // R10
        end
      end
      sram_host_pkg::ST_IDLE: begin
        if (REQ_VALID && lanes_ok && REQ_WRITE) begin
          nxt_state = sram_host_pkg::ST_WRITE;
          tmr_load = 1'b1;
          tmr_val = STORE_LD; // R8
        end else if (REQ_VALID && lanes_ok) begin
          nxt_state = sram_host_pkg::ST_READ;
          tmr_load = 1'b1;
          tmr_val = READ_LD;
        end
      end
      sram_host_pkg::ST_READ: begin
        if (tmr_done) begin
          nxt_state = sram_host_pkg::ST_READ_DONE;
        end
      end
      sram_host_pkg::ST_READ_DONE: begin
        nxt_state = sram_host_pkg::ST_TURN;
        tmr_load = 1'b1;
        tmr_val = RELEASE_LD; // R14
      end
      sram_host_pkg::ST_TURN: begin
        if (tmr_done) begin
          nxt_state = sram_host_pkg::ST_IDLE;
        end
      end
      sram_host_pkg::ST_WRITE: begin
        if (tmr_done) begin
          nxt_state = sram_host_pkg::ST_WRITE_END;
        end
      end
      sram_host_pkg::ST_WRITE_END: begin
        nxt_state = sram_host_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = sram_host_pkg::ST_IDLE;
      end
    endcase
  end

  // pin levels per state
  wire logic nxt_cs_n = ~((nxt_state == sram_host_pkg::ST_READ) |
                          (nxt_state == sram_host_pkg::ST_READ_DONE) |
                          (nxt_state == sram_host_pkg::ST_WRITE));
  wire logic nxt_oe_n = ~((nxt_state == sram_host_pkg::ST_READ) |
                          (nxt_state == sram_host_pkg::ST_READ_DONE));
  // strobe low only inside the write phase; high throughout reads
  wire logic nxt_we_n = ~(nxt_state == sram_host_pkg::ST_WRITE); // R6
  // data driven only in write and write end, output drive kept high there
  wire logic nxt_dq_oe = (nxt_state == sram_host_pkg::ST_WRITE) |
                         (nxt_state == sram_host_pkg::ST_WRITE_END); // R7
  wire logic capture = (state_ff == sram_host_pkg::ST_READ) & tmr_done;

  ////////////////////////////////////////////////////////////////////////
  // sequencer and pin registers
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff <= sram_host_pkg::ST_POWERUP;
      cs_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cs_n_ff <= nxt_cs_n; // R4 R5
      oe_n_ff <= nxt_oe_n;
      we_n_ff <= nxt_we_n;
      dq_oe_ff <= nxt_dq_oe;
    end
  end

  // request capture; address set with or before chip select
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_ff <= '0;
      lanes_ff <= 2'h0;
      wdata_ff <= 16'h0000;
    end else if (take_req) begin
      addr_ff <= REQ_ADDR; // R9
      lanes_ff <= REQ_LANES;
      wdata_ff <= REQ_WDATA;
    end
  end

  // powerup timer kick: first cycle after reset release
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      kick_ff <= 1'b1;
    end else begin
      kick_ff <= 1'b0;
    end
  end

  // data pin synchroniser and read capture
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dq_s1_ff <= 16'h0000;
      dq_s2_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      rsp_ff <= 1'b0;
    end else begin
      dq_s1_ff <= DQ_IN;
      dq_s2_ff <= dq_s1_ff;
      rsp_ff <= capture;
      if (capture) begin
        rdata_ff <= dq_s2_ff;
      end
    end
  end

  // outputs; byte selects follow chip select, unselected lanes stay high
  assign MEM_ADDR = addr_ff;
  assign CHIP_SEL_N = cs_n_ff;
  assign OUT_DRIVE_N = oe_n_ff;
  assign STORE_N = we_n_ff;
  assign LOW_BYTE_SEL_N = cs_n_ff | ~lanes_ff[0];
  assign HIGH_BYTE_SEL_N = cs_n_ff | ~lanes_ff[1];
  assign DQ_OUT = wdata_ff;
  assign DQ_OE = dq_oe_ff;
  assign REQ_READY = in_idle & ~kick_ff;
  assign RSP_VALID = rsp_ff;
  assign RSP_RDATA = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_strobe_fall;
    $fell(STORE_N);
  endsequence

  a_read_strobe_high: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !OUT_DRIVE_N |-> STORE_N) // R6
    else $error("store strobe low during read");

  a_no_drive_contend: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    DQ_OE |-> OUT_DRIVE_N) // R7
    else $error("host drives while memory may drive");

  a_strobe_width: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_strobe_fall |-> !STORE_N [*1] ##1 !STORE_N [*1]) // R8
    else $error("store strobe too short");

  a_write_overlap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !STORE_N |-> !CHIP_SEL_N && !(LOW_BYTE_SEL_N && HIGH_BYTE_SEL_N)) // R4
    else $error("write without full overlap");

  a_write_end_data: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(STORE_N) |-> DQ_OE && $stable(DQ_OUT) && $stable(MEM_ADDR)) // R5
    else $error("data changed at write end");

  a_addr_stable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !CHIP_SEL_N && !$rose(CHIP_SEL_N) && !$fell(CHIP_SEL_N)
      |-> $stable(MEM_ADDR)) // R9
    else $error("address moved during select");

  a_settle_wait: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $past(state_ff) == sram_host_pkg::ST_POWERUP |-> CHIP_SEL_N) // R10
    else $error("access before supply settle");

  a_turnaround: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(OUT_DRIVE_N) |-> !DQ_OE [*2]) // R14
    else $error("host drove right after read");

endmodule

// ==== sram_byte_model.sv ====
/*
  behavioural model of the byte-lane memory on the far side.
  assumes the pins come from sram_host_ctrl; the bench resolves the bus.
*/
module sram_byte_model (
  input wire logic [18:0] addr,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic lb_n,
  input wire logic hb_n,
  input wire logic [15:0] dq,
  output logic [15:0] q,
  output logic on_lo,
  output logic on_hi
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [256];
  logic [15:0] flip [256];
  logic [15:0] wd;
  logic [1:0] wl;
  logic [7:0] wa;
  // write overlap of select, strobe and a lane
  wire wr_act = !cs_n && !we_n && !(lb_n && hb_n);
  // lane drive only in a read, none when deselected
  wire rd_lo = !cs_n && !oe_n && we_n && !lb_n;
  wire rd_hi = !cs_n && !oe_n && we_n && !hb_n;
  // release after 1 ns, turn-on after 3 ns
  assign #(3, 1) on_lo = rd_lo;
  assign #(3, 1) on_hi = rd_hi;
  // reads give the corrected word, flips stay stored
  assign q = mem[addr[7:0]];
  //////////////////////////////////////////////////////////////////////
  // empty array at start
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
      flip[i] = 16'h0000;
    end
  end
  // lanes, address and data followed while the overlap lasts;
  // the full condition is tested here so pin update order cannot leak in
  always @* begin
    if (!cs_n && !we_n && !(lb_n && hb_n)) begin
      wl = ~{hb_n, lb_n};
      wa = addr[7:0];
      wd = dq;
    end
  end
  // first rising control ends the write, other lane kept
  always @(negedge wr_act) begin
    if (wl[0] === 1'b1) begin
      mem[wa][7:0] = wd[7:0];
      flip[wa][7:0] = 8'h00;
    end
    if (wl[1] === 1'b1) begin
      mem[wa][15:8] = wd[15:8];
      flip[wa][15:8] = 8'h00;
    end
  end
  // flips one stored bit on command of the bench
  task automatic corrupt(input int a, input int b);
    flip[a][b] = ~flip[a][b];
  endtask
endmodule

// ==== async_sram_byte_port_tb.sv ====
/*
  self-checking bench for sram_host_ctrl against sram_byte_model.
  assumes a 25 MHz clock and a short power-up count.
*/
`include "sram_host_defines.svh"
module async_sram_byte_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int S = 4;
  logic REF_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [18:0] REQ_ADDR = 19'h00000;
  logic [1:0] REQ_LANES = 2'h0;
  logic [15:0] REQ_WDATA = 16'h0000;
  logic [15:0] dq_last = 16'h0000;
  wire REQ_READY, RSP_VALID, CHIP_SEL_N, OUT_DRIVE_N, STORE_N, DQ_OE;
  wire LOW_BYTE_SEL_N, HIGH_BYTE_SEL_N, on_lo, on_hi;
  wire [15:0] RSP_RDATA, DQ_OUT, mq, dq_bus;
  wire [18:0] MEM_ADDR;
  int errors = 0;
  int check_count = 0;
  int viol = 0;
  int cs_falls = 0;
  int st_len = 0;
  logic [18:0] a_prev;
  logic cs_last = 1'b1;
  logic [15:0] rd;
  sram_host_ctrl #(.SETTLE_CYC(S)) DUT (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
    .REQ_LANES(REQ_LANES), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .MEM_ADDR(MEM_ADDR),
    .CHIP_SEL_N(CHIP_SEL_N), .OUT_DRIVE_N(OUT_DRIVE_N), .STORE_N(STORE_N),
    .LOW_BYTE_SEL_N(LOW_BYTE_SEL_N), .HIGH_BYTE_SEL_N(HIGH_BYTE_SEL_N),
    .DQ_IN(dq_bus), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));
  sram_byte_model MEM (.addr(MEM_ADDR), .cs_n(CHIP_SEL_N),
    .oe_n(OUT_DRIVE_N), .we_n(STORE_N), .lb_n(LOW_BYTE_SEL_N),
    .hb_n(HIGH_BYTE_SEL_N), .dq(dq_bus), .q(mq), .on_lo(on_lo),
    .on_hi(on_hi));
  //////////////////////////////////////////////////////////////////////
  // released lanes show the inverse of the last level
  assign dq_bus[7:0] = DQ_OE ? DQ_OUT[7:0] : on_lo ? mq[7:0] : ~dq_last[7:0];
  assign dq_bus[15:8] = DQ_OE ? DQ_OUT[15:8] : on_hi ? mq[15:8] :
    ~dq_last[15:8];
  // clock and last bus level
  always #20 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) dq_last <= dq_bus;
  // bus fights at any instant
  always @(DQ_OE, on_lo, on_hi) if (DQ_OE && (on_lo || on_hi)) viol++;
  always @(negedge CHIP_SEL_N) if (!SYS_RST) cs_falls++;
  // pin order watched mid-cycle
  always @(negedge REF_CLK) begin
    if (!OUT_DRIVE_N && !STORE_N) viol++;
    if (!CHIP_SEL_N && !cs_last && MEM_ADDR !== a_prev) viol++;
    if (!STORE_N) st_len++;
    else if (st_len > 0 && st_len < `STORE_LOW_CYC) viol++;
    if (STORE_N) st_len = 0;
    a_prev = MEM_ADDR;
    cs_last = CHIP_SEL_N;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one request, waits until taken, then for read data
  task automatic acc(input logic wr, input logic [18:0] a,
                     input logic [1:0] ln, input logic [15:0] wd);
    int n;
    @(posedge REF_CLK);
    REQ_VALID <= 1'b1;
    REQ_WRITE <= wr;
    REQ_ADDR <= a;
    REQ_LANES <= ln;
    REQ_WDATA <= wd;
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
    end while (REQ_READY !== 1'b1 && n < 60);
    @(posedge REF_CLK);
    REQ_VALID <= 1'b0;
    while (!wr && RSP_VALID !== 1'b1 && n < 60) begin
      @(negedge REF_CLK);
      n++;
    end
    rd = RSP_RDATA;
    if (n >= 60) begin
      errors++;
      stop_test();
    end
  endtask
  // ready must wait the full power-up count
  task automatic t_powerup();
    int n;
    n = 0;
    while (REQ_READY !== 1'b1 && n < 100) begin
      @(negedge REF_CLK);
      n++;
    end
    chk("powerup_wait_ok", 16'h0001, 16'(n >= S && n <= S + 3));
    chk("early_selects", 16'h0000, 16'(cs_falls));
  endtask
  // full word, then lane writes merged into it
  task automatic t_lanes();
    acc(1'b1, 19'h00034, 2'h3, 16'h1234);
    acc(1'b0, 19'h00034, 2'h3, 16'h0000);
    chk("full_word", 16'h1234, rd);
    acc(1'b1, 19'h00034, 2'h1, 16'hFFEE);
    acc(1'b0, 19'h00034, 2'h3, 16'h0000);
    chk("low_lane_write", 16'h12EE, rd);
    acc(1'b1, 19'h00034, 2'h2, 16'hABCD);
    acc(1'b0, 19'h00034, 2'h1, 16'h0000);
    chk("low_lane_read", 16'h00EE, {8'h00, rd[7:0]});
    acc(1'b0, 19'h00034, 2'h2, 16'h0000);
    chk("high_lane_read", 16'hAB00, {rd[15:8], 8'h00});
  endtask
  // single-bit error corrected on read, stored copy unchanged
  task automatic t_ecc();
    acc(1'b1, 19'h40005, 2'h3, 16'h0F0F);
    // let the write close before the stored bit is flipped
    repeat (6) @(negedge REF_CLK);
    MEM.corrupt(5, 3);
    acc(1'b0, 19'h40005, 2'h3, 16'h0000);
    chk("corrected_read", 16'h0F0F, rd);
    chk("raw_kept", 16'h0F07, MEM.mem[5] ^ MEM.flip[5]);
  endtask
  // lanes 00 never reach the pins
  task automatic t_refuse();
    int c;
    c = cs_falls;
    @(posedge REF_CLK);
    REQ_VALID <= 1'b1;
    REQ_LANES <= 2'h0;
    repeat (8) @(posedge REF_CLK);
    REQ_VALID <= 1'b0;
    chk("empty_lanes", 16'(c), 16'(cs_falls));
  endtask
  // read, write, read back to back
  task automatic t_b2b();
    acc(1'b0, 19'h00034, 2'h3, 16'h0000);
    acc(1'b1, 19'h00077, 2'h3, 16'h5AA5);
    acc(1'b0, 19'h00077, 2'h3, 16'h0000);
    chk("turnaround_data", 16'h5AA5, rd);
    chk("pin_order", 16'h0000, 16'(viol));
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    t_powerup();
    t_lanes();
    t_ecc();
    t_refuse();
    t_b2b();
    stop_test();
  end
endmodule
